// >>> rtl/ase_top.sv
// Purpose: async serial element: 16x baud generator, tx, rx, modem, irq id
// Assumes: strobes synchronous to mclk_in; serial input may be asynchronous, registered twice inside
// Notes:   read data valid the cycle after the read strobe
`timescale 1ns/1ps
module ase_top (
    // clock and reset
    input  wire logic                    mclk_in,
    input  wire logic                    rst_n_in,
    // register port
    input  wire ase_pkg::ase_bus_req_t   bus_in,
    output logic [7:0]                   rdata_out,
    // serial line
    input  wire logic                    sin_in,
    output logic                         sout_out,
    // modem lines
    input  wire ase_pkg::ase_modem_in_t  modem_in,
    output ase_pkg::ase_modem_out_t      modem_out,
    output logic                         irq_out
);
    import ase_pkg::*;

    logic        rst_s1, rst_n;
    logic [7:0]  lctl, mctl, scr;
    logic [3:0]  ien;
    logic [15:0] divisor, bcnt;
    logic        tick;
    logic        loop_on;
    // transmit
    logic [7:0]  tx_hold_byte, tsr;
    logic        thr_empty, tx_busy;
    logic [3:0]  tx_ovs;
    logic [3:0]  tx_bit;
    logic [1:0]  tx_ph;
    logic        tx_line, tx_par, tx_half;
    // receive
    logic [7:0]  rx_byte, rsr;
    logic        rx_ready_flag, overrun, parity_err_flag;
    logic        framing_err_flag, break_seen_flag;
    logic [3:0]  rx_ovs, rx_bit;
    logic [1:0]  rx_ph;
    logic        rx_par, rx_zero, rx_s1, rx_s2;
    logic [3:0]  mdm_prev, mdm_chg;
    logic        tx_hold_empty_flag_irq_seen;

    // async assert, release through two flops
    assign rst_n = rst_s1 ? 1'b1 : 1'b0;
    logic rst_s0;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s0 <= 1'b0;
            rst_s1 <= 1'b0;
        end else begin
            rst_s0 <= 1'b1;
            rst_s1 <= rst_s0;
        end
    end

    // decode
    wire        divisor_access_bit    = lctl[7];
    wire [3:0]  nbits   = {2'b00, lctl[1:0]} + 4'h5;
    wire        stop2   = lctl[2];
    wire        par_on  = lctl[3];
    wire        par_even = lctl[4];
    wire        par_stick = lctl[5];
    wire        brk     = lctl[6];
    assign loop_on = mctl[4];
    wire        wr_data = bus_in.wr && bus_in.addr == ASE_OFS_DATA && !divisor_access_bit;
    wire        rd_data = bus_in.rd && bus_in.addr == ASE_OFS_DATA && !divisor_access_bit;
    wire        rd_lstat = bus_in.rd && bus_in.addr == ASE_OFS_LSTAT;
    wire        rd_mstat = bus_in.rd && bus_in.addr == ASE_OFS_MSTAT;
    wire        rd_ident = bus_in.rd && bus_in.addr == ASE_OFS_IDENT;
    // loopback routes modem outputs to status inputs
    wire [3:0]  mdm_live = loop_on ? {mctl[1], mctl[0], mctl[2], mctl[3]}
                         : {modem_in.cts, modem_in.dsr, modem_in.ri,
                            modem_in.dcd};
    wire        rx_pin  = loop_on ? tx_line : sin_in;
    wire        tsr_empty = !tx_busy;

    // register writes; reserved bits stored as zero
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            lctl    <= ASE_LCTL_RST;
            mctl    <= 8'h00;
            scr     <= 8'h00;
            ien     <= 4'h0;
            divisor <= ASE_DIV_RST;
        end else if (bus_in.wr) begin
            case (bus_in.addr)
                ASE_OFS_DATA: if (divisor_access_bit) divisor[7:0] <= bus_in.wdata;
                ASE_OFS_IEN: begin
                    if (divisor_access_bit) divisor[15:8] <= bus_in.wdata;
                    else ien <= bus_in.wdata[3:0];
                end
                ASE_OFS_LCTL: lctl <= bus_in.wdata;
                ASE_OFS_MCTL: mctl <= {3'h0, bus_in.wdata[4:0]};
                ASE_OFS_SCR:  scr  <= bus_in.wdata;
                default: ;
            endcase
        end
    end

    // baud generator: one tick per divisor clocks, divisor 0 treated as 1
    // tick is registered; a new divisor applies to the count already in progress
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            bcnt <= 16'h0000;
            tick <= 1'b0;
        end else if (bcnt + 16'h0001 >= divisor) begin
            bcnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            bcnt <= bcnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    // transmitter: phases 0 start, 1 data, 2 parity, 3 stop
    // half a stop bit only for the five-bit long stop
    assign tx_half = !stop2 ? 1'b0 : (lctl[1:0] == 2'b00);
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_hold_byte       <= 8'h00;
            thr_empty <= 1'b1;
            tsr       <= 8'h00;
            tx_busy   <= 1'b0;
            tx_ovs    <= 4'h0;
            tx_bit    <= 4'h0;
            tx_ph     <= 2'h0;
            tx_line   <= 1'b1;
            tx_par    <= 1'b0;
        end else begin
            if (wr_data) begin
                tx_hold_byte       <= bus_in.wdata;
                thr_empty <= 1'b0;
            end
            // a write to the holding byte defers the load by one cycle
            if (!tx_busy && !thr_empty && !wr_data) begin
                tsr       <= tx_hold_byte;
                thr_empty <= 1'b1;
                tx_busy   <= 1'b1;
                tx_ph     <= 2'h0;
                tx_ovs    <= 4'h0;
                tx_bit    <= 4'h0;
                tx_par    <= 1'b0;
                tx_line   <= 1'b0;
            end else if (tx_busy && tick) begin
                tx_ovs <= tx_ovs + 4'h1;
                if (tx_ovs == ASE_OVS_LAST) begin
                    case (tx_ph)
                        2'h0, 2'h1: begin
                            if (tx_ph == 2'h1 && tx_bit == nbits) begin
                                tx_ph   <= par_on ? 2'h2 : 2'h3;
                                tx_bit  <= 4'h0;
                                tx_line <= par_on ? (par_stick ? !par_even
                                           : (tx_par ^ !par_even)) : 1'b1;
                            end else begin
                                tx_ph   <= 2'h1;
                                tx_line <= tsr[0];
                                tx_par  <= tx_par ^ tsr[0];
                                tsr     <= {1'b0, tsr[7:1]};
                                tx_bit  <= tx_bit + 4'h1;
                            end
                        end
                        2'h2: begin
                            tx_ph   <= 2'h3;
                            tx_line <= 1'b1;
                        end
                        default: begin
                            tx_bit <= tx_bit + 4'h1;
                            if (!stop2 || tx_bit == 4'h1) begin
                                tx_busy <= 1'b0;
                            end
                        end
                    endcase
                end else if (tx_ph == 2'h3 && tx_half && tx_bit == 4'h1
                             && tx_ovs == ASE_OVS_MID) begin
                    tx_busy <= 1'b0;
                end
            end
        end
    end
    assign sout_out = loop_on ? 1'b1 : (tx_line & !brk);

    // receiver; serial input registered twice
    // only rx_s2 is read by the frame logic
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= rx_pin;
            rx_s2 <= rx_s1;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_byte              <= 8'h00;
            rsr              <= 8'h00;
            rx_ready_flag    <= 1'b0;
            overrun          <= 1'b0;
            parity_err_flag  <= 1'b0;
            framing_err_flag <= 1'b0;
            break_seen_flag  <= 1'b0;
            rx_ovs           <= 4'h0;
            rx_bit           <= 4'h0;
            rx_ph            <= 2'h0;
            rx_par           <= 1'b0;
            rx_zero          <= 1'b1;
        end else begin
            if (rd_data) rx_ready_flag <= 1'b0;
            if (rd_lstat) begin
                overrun          <= 1'b0;
                parity_err_flag  <= 1'b0;
                framing_err_flag <= 1'b0;
                break_seen_flag  <= 1'b0;
            end
            if (tick) begin
                case (rx_ph)
                    2'h0: begin
                        // eight low ticks make a start; short glitches drop
                        if (!rx_s2) begin
                            rx_ovs <= rx_ovs + 4'h1;
                            if (rx_ovs == ASE_OVS_MID) begin
                                rx_ph  <= 2'h1;
                                rx_ovs <= 4'h0;
                                rx_bit <= 4'h0;
                                rx_par <= 1'b0;
                                rx_zero <= 1'b1;
                                rsr    <= 8'h00;
                            end
                        end else begin
                            rx_ovs <= 4'h0;
                        end
                    end
                    2'h1: begin
                        rx_ovs <= rx_ovs + 4'h1;
                        if (rx_ovs == ASE_OVS_LAST) begin
                            rx_bit  <= rx_bit + 4'h1;
                            rx_par  <= rx_par ^ rx_s2;
                            rx_zero <= rx_zero & !rx_s2;
                            rsr     <= {rx_s2, rsr[7:1]};
                            if (rx_bit + 4'h1 == nbits) begin
                                rx_ph <= par_on ? 2'h2 : 2'h3;
                            end
                        end
                    end
                    2'h2: begin
                        rx_ovs <= rx_ovs + 4'h1;
                        if (rx_ovs == ASE_OVS_LAST) begin
                            rx_ph   <= 2'h3;
                            rx_zero <= rx_zero & !rx_s2;
                            rx_par  <= par_stick ? (rx_s2 == par_even)
                                     : ((rx_par ^ rx_s2) == par_even);
                        end
                    end
                    default: begin
                        rx_ovs <= rx_ovs + 4'h1;
                        // a frame's flags win over a clearing read
                        if (rx_ovs == ASE_OVS_LAST) begin
                            rx_ph            <= 2'h0;
                            rx_ovs           <= 4'h0;
                            rx_byte              <= rsr >> (4'h8 - nbits);
                            rx_ready_flag    <= 1'b1;
                            overrun          <= rx_ready_flag && !rd_data;
                            parity_err_flag  <= par_on && rx_par;
                            framing_err_flag <= !rx_s2;
                            break_seen_flag  <= rx_zero && !rx_s2;
                        end
                    end
                endcase
            end
        end
    end

    // modem status change flags; a change beats a clearing read
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mdm
            wire ev = (gi == 1) ? (mdm_prev[gi] && !mdm_live[gi])
                                : (mdm_prev[gi] != mdm_live[gi]);
            always_ff @(posedge mclk_in or negedge rst_n) begin
                if (!rst_n) begin
                    mdm_prev[gi] <= 1'b0;
                    mdm_chg[gi]  <= 1'b0;
                end else begin
                    mdm_prev[gi] <= mdm_live[gi];
                    mdm_chg[gi]  <= ev | (mdm_chg[gi] & !rd_mstat);
                end
            end
        end
    endgenerate
    // bit order cts,dsr,ri,dcd -> change flags in status bits 0,1,2,3
    wire [3:0] chg_bits = {mdm_chg[0], mdm_chg[1], mdm_chg[2], mdm_chg[3]};
    wire [3:0] live_bits = {mdm_live[0], mdm_live[1], mdm_live[2], mdm_live[3]};

    wire [7:0] lstat = {1'b0, tsr_empty && thr_empty, thr_empty,
                        break_seen_flag, framing_err_flag, parity_err_flag,
                        overrun, rx_ready_flag};
    wire [7:0] mstat = {live_bits, chg_bits};

    // interrupt sources in fixed priority
    wire src_line = ien[2] && (overrun | parity_err_flag | framing_err_flag
                               | break_seen_flag);
    wire src_rx   = ien[0] && rx_ready_flag;
    wire src_tx   = ien[1] && thr_empty && !tx_hold_empty_flag_irq_seen;
    wire src_mdm  = ien[3] && (|mdm_chg);
    wire pend     = src_line | src_rx | src_tx | src_mdm;
    wire [1:0] id_code = src_line ? ASE_ID_LINE : src_rx ? ASE_ID_RXAV
                       : src_tx ? ASE_ID_TXE : ASE_ID_MDM;
    wire [7:0] ident = {5'h00, pend ? id_code : 2'h0, !pend};

    // tx empty source: held off once an ident read has reported it,
    // until the holding byte is written again
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_hold_empty_flag_irq_seen <= 1'b0;
        end else if (wr_data || !thr_empty) begin
            tx_hold_empty_flag_irq_seen <= 1'b0;
        end else if (rd_ident && id_code == ASE_ID_TXE && pend) begin
            tx_hold_empty_flag_irq_seen <= 1'b1;
        end
    end

    // out2 gates the pin; loopback keeps it quiet
    assign irq_out = pend && mctl[3] && !loop_on;

    // read mux; reserved bits read back as zero
    wire [7:0] rsel =
        bus_in.addr == ASE_OFS_DATA ? (divisor_access_bit ? divisor[7:0] : rx_byte)
      : bus_in.addr == ASE_OFS_IEN  ? (divisor_access_bit ? divisor[15:8] : {4'h0, ien})
      : bus_in.addr == ASE_OFS_IDENT ? ident
      : bus_in.addr == ASE_OFS_LCTL ? lctl
      : bus_in.addr == ASE_OFS_MCTL ? mctl
      : bus_in.addr == ASE_OFS_LSTAT ? lstat
      : bus_in.addr == ASE_OFS_MSTAT ? mstat : scr;

    // read data held until the next read strobe
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) rdata_out <= 8'h00;
        else if (bus_in.rd) rdata_out <= rsel;
    end

    assign modem_out.dtr  = mctl[0] && !loop_on;
    assign modem_out.rts  = mctl[1] && !loop_on;
    assign modem_out.out1 = mctl[2] && !loop_on;
    assign modem_out.out2 = mctl[3] && !loop_on;
endmodule

// >>> shared/ase_pkg.sv
// Purpose: constants and types for the async serial element
// Assumes: byte-wide registers at word indices 0 to 7
// Notes:   one clock, synchronous strobes
package ase_pkg;
    localparam logic [2:0] ASE_OFS_DATA  = 3'h0;
    localparam logic [2:0] ASE_OFS_IEN   = 3'h1;
    localparam logic [2:0] ASE_OFS_IDENT = 3'h2;
    localparam logic [2:0] ASE_OFS_LCTL  = 3'h3;
    localparam logic [2:0] ASE_OFS_MCTL  = 3'h4;
    localparam logic [2:0] ASE_OFS_LSTAT = 3'h5;
    localparam logic [2:0] ASE_OFS_MSTAT = 3'h6;
    localparam logic [2:0] ASE_OFS_SCR   = 3'h7;
    localparam logic [7:0]  ASE_LCTL_RST = 8'h03;
    localparam logic [15:0] ASE_DIV_RST  = 16'h000C;
    localparam logic [3:0]  ASE_OVS_LAST = 4'hF;
    localparam logic [3:0]  ASE_OVS_MID  = 4'h7;
    localparam logic [1:0]  ASE_ID_LINE  = 2'h3;
    localparam logic [1:0]  ASE_ID_RXAV  = 2'h2;
    localparam logic [1:0]  ASE_ID_TXE   = 2'h1;
    localparam logic [1:0]  ASE_ID_MDM   = 2'h0;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ase_bus_req_t;

    typedef struct packed {
        logic cts;
        logic dsr;
        logic ri;
        logic dcd;
    } ase_modem_in_t;

    typedef struct packed {
        logic dtr;
        logic rts;
        logic out1;
        logic out2;
    } ase_modem_out_t;
endpackage

// >>> bench/ase_props.sv
// Purpose: port-level checks for the async serial element
// Assumes: sees only the top-level ports
// Notes:   loop state is tracked from modem control writes
`timescale 1ns/1ps
module ase_props (
    // clock and reset
    input wire logic                    mclk_in,
    input wire logic                    rst_n_in,
    // observed ports
    input wire ase_pkg::ase_bus_req_t   bus_in,
    input wire logic [7:0]              rdata_out,
    input wire logic                    sout_out,
    input wire ase_pkg::ase_modem_in_t  modem_in,
    input wire ase_pkg::ase_modem_out_t modem_out,
    input wire logic                    irq_out
);
    import ase_pkg::*;
    logic       loop_q;
    wire        mctl_wr = bus_in.wr && (bus_in.addr == ASE_OFS_MCTL);
    wire        rd_ms   = bus_in.rd && (bus_in.addr == ASE_OFS_MSTAT);
    wire        rd_id   = bus_in.rd && (bus_in.addr == ASE_OFS_IDENT);
    wire        rd_ls   = bus_in.rd && (bus_in.addr == ASE_OFS_LSTAT);
    wire [3:0]  mo_exp  = {bus_in.wdata[0], bus_in.wdata[1],
                           bus_in.wdata[2], bus_in.wdata[3]};
    wire [3:0]  ms_live = {modem_in.dcd, modem_in.ri,
                           modem_in.dsr, modem_in.cts};
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) loop_q <= 1'b0;
        else if (mctl_wr) loop_q <= bus_in.wdata[4];
    end
    sequence s_low8;
        (!sout_out) [*8];
    endsequence
    property p_mctl_out;
        mctl_wr && !bus_in.wdata[4] |=> modem_out == $past(mo_exp);
    endproperty
    property p_loop;
        mctl_wr && bus_in.wdata[4] |=> (modem_out == 4'h0) && sout_out;
    endproperty
    property p_mstat_live;
        rd_ms && !loop_q |=> rdata_out[7:4] == $past(ms_live);
    endproperty
    property p_ident_rsvd;
        rd_id |=> rdata_out[7:3] == 5'h00;
    endproperty
    property p_lstat_rsvd;
        rd_ls |=> !rdata_out[7];
    endproperty
    property p_irq_gate;
        irq_out |-> modem_out.out2;
    endproperty
    property p_rdata_hold;
        !$past(bus_in.rd) |-> $stable(rdata_out);
    endproperty
    property p_bit_len;
        $fell(sout_out) |-> s_low8;
    endproperty
    a_mctl_out: assert property (p_mctl_out)
        else $error("modem outputs differ from control write");
    a_loop: assert property (p_loop)
        else $error("loopback did not quiet the outputs");
    a_mstat_live: assert property (p_mstat_live)
        else $error("modem status does not show live inputs");
    a_ident_rsvd: assert property (p_ident_rsvd)
        else $error("ident unused bits not zero");
    a_lstat_rsvd: assert property (p_lstat_rsvd)
        else $error("line status bit 7 not zero");
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq raised without out2");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");
    a_bit_len: assert property (p_bit_len)
        else $error("serial low level shorter than 8 clocks");
endmodule

// >>> bench/ase_line_model.sv
// Purpose: serial terminal on the far side of the line
// Assumes: bit time counted in cycles of the shared clock
// Notes:   receive side decodes eight bits lsb first and one stop
`timescale 1ns/1ps
module ase_line_model (
    // clock
    input  wire logic clk_in,
    // serial line
    input  wire logic sout_in,
    output logic      sin_out
);
    int unsigned bit_clks  = 16;
    int unsigned got_count = 0;
    logic [7:0]  got_byte  = 8'h00;
    logic        got_stop  = 1'b1;
    initial sin_out = 1'b1;
    // sends n levels lsb first, then one idle bit time
    task automatic send_bits(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            sin_out <= bits[i];
            repeat (bit_clks) @(posedge clk_in);
        end
        sin_out <= 1'b1;
        repeat (bit_clks) @(posedge clk_in);
    endtask
    always begin
        @(negedge sout_in);
        repeat (bit_clks / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_clks) @(posedge clk_in);
            got_byte[i] = sout_in;
        end
        repeat (bit_clks) @(posedge clk_in);
        got_stop = sout_in;
        got_count++;
    end
endmodule

// >>> bench/tb_top.sv
// Purpose: register-level test of the async serial element
// Assumes: divisor 1 gives 16 clocks per bit
// Notes:   partner terminal sends and receives frames
`timescale 1ns/1ps
module tb_top;
    import ase_pkg::*;
    logic           mclk_in  = 1'b0;
    logic           rst_n_in = 1'b0;
    ase_bus_req_t   bus_in   = '0;
    ase_modem_in_t  modem_in = '0;
    logic [7:0]     rdata_out;
    logic           sin_in;
    logic           sout_out;
    logic           irq_out;
    ase_modem_out_t modem_out;
    int             errors = 0;
    int             num_checks = 0;
    int             cycles = 0;
    logic [7:0]     tmp;
    logic [7:0]     rst_tbl [8] = '{8'h00, 8'h00, 8'h01, 8'h03,
                                    8'h00, 8'h60, 8'h00, 8'h00};
    always #2 mclk_in = ~mclk_in;
    ase_top ase_top_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .bus_in(bus_in), .rdata_out(rdata_out), .sin_in(sin_in),
        .sout_out(sout_out), .modem_in(modem_in),
        .modem_out(modem_out), .irq_out(irq_out));
    ase_line_model ase_line_model_i (.clk_in(mclk_in),
        .sout_in(sout_out), .sin_out(sin_in));
    task automatic test_done();
        if (errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus_in.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_in);
        bus_in.rd <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("reg%0d", a), d, exp);
    endtask
    task automatic sendf(input logic [7:0] d, input logic pon,
                         input logic par, input logic stp);
        if (pon) ase_line_model_i.send_bits({5'h1F, stp, par, d, 1'b0}, 11);
        else ase_line_model_i.send_bits({6'h3F, stp, d, 1'b0}, 10);
    endtask
    task automatic wait_tx();
        int unsigned n0;
        n0 = ase_line_model_i.got_count;
        for (int i = 0; i < 1000; i++)
            if (ase_line_model_i.got_count == n0) @(posedge mclk_in);
        chk("tx_done", {7'h00, ase_line_model_i.got_count != n0},
            8'h01);
        repeat (ase_line_model_i.bit_clks) @(posedge mclk_in);
    endtask
    task automatic setm(input logic [3:0] v);
        @(posedge mclk_in);
        modem_in <= v;
        repeat (4) @(posedge mclk_in);
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        repeat (4) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        for (int i = 0; i < 8; i++) rdchk(i[2:0], rst_tbl[i]);
        wr(3'h3, 8'h83);
        rdchk(3'h0, 8'h0C);
        rdchk(3'h1, 8'h00);
        wr(3'h0, 8'h34);
        wr(3'h1, 8'h12);
        rdchk(3'h0, 8'h34);
        rdchk(3'h1, 8'h12);
        rdchk(3'h5, 8'h60);
        wr(3'h3, 8'h03);
        rdchk(3'h1, 8'h00);
        wr(3'h7, 8'hA5);
        wr(3'h2, 8'hFF);
        rdchk(3'h7, 8'hA5);
        rdchk(3'h2, 8'h01);
        // char length i+5 at divisor i+1; idle fills the top bits
        for (int i = 0; i < 4; i++) begin
            ase_line_model_i.bit_clks = 16 * (i + 1);
            wr(3'h3, 8'h80 | i[7:0]);
            wr(3'h0, 8'h01 + i[7:0]);
            wr(3'h1, 8'h00);
            wr(3'h3, i[7:0]);
            wr(3'h0, 8'h5A);
            wait_tx();
            chk("tx_len", ase_line_model_i.got_byte,
                8'h5A | (8'hFF << (5 + i)));
        end
        ase_line_model_i.bit_clks = 16;
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h01);
        wr(3'h3, 8'h03);
        wr(3'h0, 8'hC6);
        wait_tx();
        chk("tx_byte", ase_line_model_i.got_byte, 8'hC6);
        chk("tx_stop", {7'h00, ase_line_model_i.got_stop}, 8'h01);
        rdchk(3'h5, 8'h60);
        // two stop bits keep the shift register busy one bit longer
        wr(3'h3, 8'h07);
        wr(3'h0, 8'h81);
        wait_tx();
        chk("tx_byte", ase_line_model_i.got_byte, 8'h81);
        rdchk(3'h5, 8'h20);
        repeat (16) @(posedge mclk_in);
        rdchk(3'h5, 8'h60);
        wr(3'h3, 8'h03);
        sendf(8'hC3, 1'b0, 1'b0, 1'b1);
        rdchk(3'h5, 8'h61);
        rdchk(3'h0, 8'hC3);
        rdchk(3'h5, 8'h60);
        wr(3'h3, 8'h1B);
        sendf(8'hC3, 1'b1, 1'b1, 1'b1);
        rdchk(3'h5, 8'h65);
        rdchk(3'h0, 8'hC3);
        sendf(8'hC3, 1'b1, 1'b0, 1'b1);
        rdchk(3'h5, 8'h61);
        rdchk(3'h0, 8'hC3);
        wr(3'h3, 8'h03);
        sendf(8'hC3, 1'b0, 1'b0, 1'b1);
        sendf(8'h3C, 1'b0, 1'b0, 1'b1);
        rdchk(3'h5, 8'h63);
        rd(3'h0, tmp);
        rdchk(3'h5, 8'h60);
        wr(3'h4, 8'h08);
        wr(3'h1, 8'h02);
        rdchk(3'h1, 8'h02);
        chk("irq", {7'h00, irq_out}, 8'h01);
        rdchk(3'h2, 8'h02);
        rdchk(3'h2, 8'h01);
        chk("irq", {7'h00, irq_out}, 8'h00);
        wr(3'h1, 8'h05);
        sendf(8'h55, 1'b0, 1'b0, 1'b0);
        rdchk(3'h2, 8'h06);
        rdchk(3'h5, 8'h69);
        rdchk(3'h2, 8'h04);
        rdchk(3'h0, 8'h55);
        rdchk(3'h2, 8'h01);
        // a low stop bit reads as a fresh start; let that frame drain
        repeat (160) @(posedge mclk_in);
        rd(3'h0, tmp);
        wr(3'h1, 8'h00);
        sendf(8'h11, 1'b0, 1'b0, 1'b1);
        chk("irq", {7'h00, irq_out}, 8'h00);
        rdchk(3'h0, 8'h11);
        wr(3'h1, 8'h08);
        setm(4'b1000);
        chk("irq", {7'h00, irq_out}, 8'h01);
        rdchk(3'h2, 8'h00);
        rdchk(3'h6, 8'h11);
        rdchk(3'h2, 8'h01);
        rdchk(3'h6, 8'h10);
        wr(3'h1, 8'h00);
        setm(4'b1010);
        rdchk(3'h6, 8'h50);
        setm(4'b1000);
        rdchk(3'h6, 8'h14);
        setm(4'b1101);
        rdchk(3'h6, 8'hBA);
        setm(4'b0000);
        rdchk(3'h6, 8'h0B);
        wr(3'h4, 8'h0F);
        chk("mout", {4'h0, modem_out}, 8'h0F);
        wr(3'h4, 8'h13);
        chk("mout", {4'h0, modem_out}, 8'h00);
        rd(3'h6, tmp);
        rdchk(3'h6, 8'h30);
        wr(3'h0, 8'h96);
        repeat (250) @(posedge mclk_in);
        rdchk(3'h0, 8'h96);
        wr(3'h4, 8'h00);
        rd(3'h6, tmp);
        wr(3'h3, 8'h43);
        repeat (10) @(posedge mclk_in);
        chk("sout", {7'h00, sout_out}, 8'h00);
        wr(3'h3, 8'h03);
        test_done();
    end
endmodule
bind ase_top ase_props ase_props_i (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .sout_out(sout_out), .modem_in(modem_in),
    .modem_out(modem_out), .irq_out(irq_out));
